// [orx_defines.svh]
// constants for the or/move/pointer-load execution block
`ifndef ORX_DEFINES_SVH
`define ORX_DEFINES_SVH
`define ORX_AW 13
`define ORX_DW 16
`define ORX_MEM_SEL 12
`define ORX_REG_W 12'h000
`define ORX_REG_STATUS 12'h004
`define ORX_REG_BANK 12'h008
`define ORX_REG_CTRL 12'h00c
`define ORX_REG_PTR0 12'h010
`define ORX_REG_PTR1 12'h014
`define ORX_REG_PTR2 12'h018
`define ORX_REG_PHASE 12'h01c
`define ORX_ST_N 4
`define ORX_ST_Z 2
`define ORX_CTRL_EXT 0
`define ORX_W_RST 8'h00
`define ORX_ST_RST 8'h00
`define ORX_BANK_RST 8'h00
`define ORX_PTR_RST 12'h000
`define ORX_OPC_ORL 8'h09
`define ORX_OPC_ORF 6'h04
`define ORX_OPC_MOVE_FILE_OP 6'h14
`define ORX_OPC_LDP 10'h3b8
`define ORX_OPC_LDP2 8'hf0
`define ORX_ACC_LIM 8'h5f
`define ORX_ACC_HI 4'hf
`endif

// [orx_pkg.sv]
// types for the or/move/pointer-load execution block
package orx_pkg;
  typedef enum logic [1:0] {
    PH_DECODE,
    PH_READ,
    PH_PROC,
    PH_WRITE
  } orx_phase_t;
  typedef enum logic [2:0] {
    OP_NONE,
    OP_ORL,
    OP_ORF,
    OP_MOVE_FILE_OP,
    OP_LDP
  } orx_op_t;
  typedef struct packed {
    logic [12:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } orx_bus_req_t;
endpackage : orx_pkg

// [orx_exec.sv]
// execution core for or-literal, or-file, move-file and pointer-load
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "orx_defines.svh"

// Behaviour
// - or-literal ors w with k into w
// - only n and z change; pointer-load none
// - or-file ors w with file register
// - d=0 writes w, d=1 writes file
// - a=0 access bank, a=1 bank select
// - extended set, a=0, f<=5fh: indexed offset
// - 8-bit file operand within 256-byte bank
// - pointer-load puts 12-bit k into pointer
// - two words: high nibble then low byte
// - move-file copies file register to destination
module orx_exec (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic [15:0] instr_i,
  input wire logic instr_valid_i,
  output logic instr_ready_o,
  input wire orx_pkg::orx_bus_req_t bus_i,
  output logic [15:0] bus_rdata_o
);

  orx_pkg::orx_phase_t ph;
  orx_pkg::orx_phase_t next_ph;
  orx_pkg::orx_op_t op;
  logic [7:0] w;
  logic [7:0] status;
  logic [7:0] bank_select_reg;
  logic ext_en;
  logic [11:0] file_pointer [3];
  logic [7:0] mem [4096];
  logic [15:0] ir;
  logic [7:0] opnd;
  logic ldp_pend;
  logic [1:0] ldp_sel;
  logic [15:0] rdata;

  // decode of a pointer index from an address, used by bus and ports
  function automatic logic [1:0] ptr_idx(input logic [11:0] a);
    ptr_idx = 2'(a[3:2]);
  endfunction : ptr_idx

  wire take = (ph == orx_pkg::PH_DECODE) && instr_valid_i;
  wire is_orl = instr_i[15:8] == `ORX_OPC_ORL;
  wire is_orf = instr_i[15:10] == `ORX_OPC_ORF;
  wire is_move_file_op = instr_i[15:10] == `ORX_OPC_MOVE_FILE_OP;
  wire is_ldp = instr_i[15:6] == `ORX_OPC_LDP;
  wire is_ldp2 = instr_i[15:8] == `ORX_OPC_LDP2;

  // latched operand fields
  wire [7:0] f_lit = ir[7:0];
  wire d_bit = ir[9];
  wire a_bit = ir[8];
  wire file_op = (op == orx_pkg::OP_ORF) || (op == orx_pkg::OP_MOVE_FILE_OP);

  // effective data address
  wire ilo = !a_bit && ext_en && (f_lit <= `ORX_ACC_LIM);
  wire [11:0] ilo_addr = 12'(file_pointer[2] + {4'h0, f_lit});
  wire [11:0] acc_addr = (f_lit <= `ORX_ACC_LIM) ? {4'h0, f_lit} :
    {`ORX_ACC_HI, f_lit};
  wire [11:0] bank_addr = {bank_select_reg[3:0], f_lit};
  wire [11:0] ea = a_bit ? bank_addr : (ilo ? ilo_addr : acc_addr);

  // result in the write phase
  wire [7:0] res = (op == orx_pkg::OP_ORL) ? (w | f_lit) :
    (op == orx_pkg::OP_ORF) ? (w | opnd) :
    opnd;
  wire in_wr = ph == orx_pkg::PH_WRITE;
  wire upd_nz = in_wr && (op == orx_pkg::OP_ORL || file_op);
  wire wr_w = in_wr && (op == orx_pkg::OP_ORL || (file_op && !d_bit));
  wire wr_mem = in_wr && file_op && d_bit;
  wire [7:0] next_status = {status[7:5], res[7], status[3],
    res == 8'h00, status[1:0]};

  // bus decode
  wire bus_mem = bus_i.addr[`ORX_MEM_SEL];
  wire [11:0] bus_off = bus_i.addr[11:0];
  wire bw_w = bus_i.wr && !bus_mem && bus_off == `ORX_REG_W;
  wire bw_st = bus_i.wr && !bus_mem && bus_off == `ORX_REG_STATUS;
  wire bw_bank = bus_i.wr && !bus_mem && bus_off == `ORX_REG_BANK;
  wire bw_ctrl = bus_i.wr && !bus_mem && bus_off == `ORX_REG_CTRL;
  wire bus_ptr = !bus_mem && bus_off >= `ORX_REG_PTR0 &&
    bus_off <= `ORX_REG_PTR2 && bus_off[1:0] == 2'h0;
  wire bw_mem = bus_i.wr && bus_mem;

  assign instr_ready_o = ph == orx_pkg::PH_DECODE;
  assign bus_rdata_o = rdata;

  // four phases per instruction cycle
  always_comb begin
    unique case (ph)
      orx_pkg::PH_DECODE: next_ph = take ? orx_pkg::PH_READ : orx_pkg::PH_DECODE;
      orx_pkg::PH_READ: next_ph = orx_pkg::PH_PROC;
      orx_pkg::PH_PROC: next_ph = orx_pkg::PH_WRITE;
      orx_pkg::PH_WRITE: next_ph = orx_pkg::PH_DECODE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ph <= orx_pkg::PH_DECODE;
    end else begin
      ph <= next_ph;
    end
  end

  // instruction latch; the second pointer-load word is taken as a literal
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ir <= 16'h0000;
      op <= orx_pkg::OP_NONE;
      ldp_pend <= 1'b0;
      ldp_sel <= 2'h0;
    end else if (take) begin
      ir <= instr_i;
      if (ldp_pend) begin
        op <= orx_pkg::OP_LDP;
        ldp_pend <= 1'b0;
      end else if (is_orl) begin
        op <= orx_pkg::OP_ORL;
      end else if (is_orf) begin
        op <= orx_pkg::OP_ORF;
      end else if (is_move_file_op) begin
        op <= orx_pkg::OP_MOVE_FILE_OP;
      end else if (is_ldp && instr_i[5:4] != 2'h3) begin
        op <= orx_pkg::OP_LDP;
        ldp_pend <= 1'b1;
        ldp_sel <= instr_i[5:4];
      end else begin
        op <= orx_pkg::OP_NONE;
      end
    end
  end

  // operand read in the second phase
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      opnd <= 8'h00;
    end else if (ph == orx_pkg::PH_READ && file_op) begin
      opnd <= mem[ea];
    end
  end

  // the core wins over a bus write landing in the same cycle
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      w <= `ORX_W_RST;
    end else if (wr_w) begin
      w <= res;
    end else if (bw_w) begin
      w <= bus_i.wdata[7:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      status <= `ORX_ST_RST;
    end else if (upd_nz) begin
      status <= next_status;
    end else if (bw_st) begin
      status <= bus_i.wdata[7:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      bank_select_reg <= `ORX_BANK_RST;
      ext_en <= 1'b0;
    end else begin
      if (bw_bank) begin
        bank_select_reg <= bus_i.wdata[7:0];
      end
      if (bw_ctrl) begin
        ext_en <= bus_i.wdata[`ORX_CTRL_EXT];
      end
    end
  end

  // no reset on data memory: contents are software's to set
  always_ff @(posedge mclk_i) begin
    if (wr_mem) begin
      mem[ea] <= res;
    end else if (bw_mem) begin
      mem[bus_off] <= bus_i.wdata[7:0];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_ptr
      wire hi_wr = in_wr && op == orx_pkg::OP_LDP && ldp_pend &&
        ldp_sel == 2'(gi);
      wire lo_wr = in_wr && op == orx_pkg::OP_LDP && !ldp_pend &&
        ldp_sel == 2'(gi);
      wire bw = bus_i.wr && bus_ptr && ptr_idx(bus_off) == 2'(gi);
      always_ff @(posedge mclk_i) begin
        if (rst_i) begin
          file_pointer[gi] <= `ORX_PTR_RST;
        end else if (hi_wr) begin
          file_pointer[gi][11:8] <= ir[3:0];
        end else if (lo_wr) begin
          file_pointer[gi][7:0] <= ir[7:0];
        end else if (bw) begin
          file_pointer[gi] <= bus_i.wdata[11:0];
        end
      end
    end
  endgenerate

  // read data stands only in the cycle after the strobe
  wire [15:0] reg_rd =
    bus_mem ? {8'h00, mem[bus_off]} :
    bus_off == `ORX_REG_W ? {8'h00, w} :
    bus_off == `ORX_REG_STATUS ? {8'h00, status} :
    bus_off == `ORX_REG_BANK ? {8'h00, bank_select_reg} :
    bus_off == `ORX_REG_CTRL ? {15'h0000, ext_en} :
    bus_ptr ? {4'h0, file_pointer[ptr_idx(bus_off) == 2'h0 ? 0 :
      (ptr_idx(bus_off) == 2'h1 ? 1 : 2)]} :
    bus_off == `ORX_REG_PHASE ? {13'h0000, ldp_pend, ph} :
    16'h0000;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= bus_i.rd ? reg_rd : 16'h0000;
    end
  end

  // checks
  a_ready_phase: assert property (@(posedge mclk_i) disable iff (rst_i)
    take |=> !instr_ready_o ##1 !instr_ready_o ##1 !instr_ready_o ##1 instr_ready_o)
    else $error("ready outside decode phase");

  a_phase_walk: assert property (@(posedge mclk_i) disable iff (rst_i)
    take |=> ph == orx_pkg::PH_READ ##1 ph == orx_pkg::PH_PROC
      ##1 ph == orx_pkg::PH_WRITE ##1 ph == orx_pkg::PH_DECODE)
    else $error("phase sequence broken");

  a_orl_result: assert property (@(posedge mclk_i) disable iff (rst_i)
    (in_wr && op == orx_pkg::OP_ORL) |=> w == ($past(w) | $past(ir[7:0])))
    else $error("or-literal result wrong");

  a_flags_nz: assert property (@(posedge mclk_i) disable iff (rst_i)
    upd_nz |=> status[`ORX_ST_N] == $past(res[7]) &&
      status[`ORX_ST_Z] == ($past(res) == 8'h00))
    else $error("n or z flag wrong");

  a_ldp_flags: assert property (@(posedge mclk_i) disable iff (rst_i)
    (in_wr && op == orx_pkg::OP_LDP && !bw_st) |=> $stable(status))
    else $error("pointer-load touched status");

  a_file_dest: assert property (@(posedge mclk_i) disable iff (rst_i)
    (in_wr && file_op && !d_bit) |=> w == $past(res))
    else $error("destination select wrong");

  a_bank_addr: assert property (@(posedge mclk_i) disable iff (rst_i)
    (file_op && a_bit) |-> ea == {bank_select_reg[3:0], ir[7:0]})
    else $error("banked address wrong");

  a_ilo_addr: assert property (@(posedge mclk_i) disable iff (rst_i)
    (file_op && !a_bit && ext_en && ir[7:0] <= 8'h5f) |->
      ea == 12'(file_pointer[2] + {4'h0, ir[7:0]}))
    else $error("indexed offset address wrong");

  a_ldp_two: assert property (@(posedge mclk_i) disable iff (rst_i)
    (take && !ldp_pend && is_ldp && instr_i[5:4] != 2'h3) |=>
      (ldp_pend && ph == orx_pkg::PH_READ) ##1 ldp_pend [*3])
    else $error("pointer-load did not wait for second word");

  a_rdata_idle: assert property (@(posedge mclk_i) disable iff (rst_i)
    !bus_i.rd |=> bus_rdata_o == 16'h0000)
    else $error("read data outside read answer");

  a_file_keep_w: assert property (@(posedge mclk_i) disable iff (rst_i)
    (in_wr && file_op && d_bit && !bw_w) |=> $stable(w))
    else $error("file destination changed w");

  a_mem_write: assert property (@(posedge mclk_i) disable iff (rst_i)
    wr_mem |=> mem[$past(ea)] == $past(res))
    else $error("file register write-back wrong");

  a_orf_result: assert property (@(posedge mclk_i) disable iff (rst_i)
    (in_wr && op == orx_pkg::OP_ORF && !d_bit) |=> w == ($past(w) | $past(opnd)))
    else $error("or-file result wrong");

  a_move_file_op_result: assert property (@(posedge mclk_i) disable iff (rst_i)
    (in_wr && op == orx_pkg::OP_MOVE_FILE_OP && !d_bit) |=> w == $past(opnd))
    else $error("move-file result wrong");

  a_opnd_read: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ph == orx_pkg::PH_READ && file_op && !bw_mem) |=> opnd == mem[$past(ea)])
    else $error("operand read from wrong location");

  a_acc_low: assert property (@(posedge mclk_i) disable iff (rst_i)
    (file_op && !a_bit && !ext_en && ir[7:0] <= `ORX_ACC_LIM) |->
      ea == {4'h0, ir[7:0]})
    else $error("access bank low address wrong");

  a_acc_high: assert property (@(posedge mclk_i) disable iff (rst_i)
    (file_op && !a_bit && ir[7:0] > `ORX_ACC_LIM) |->
      ea == {`ORX_ACC_HI, ir[7:0]})
    else $error("access bank high address wrong");

  a_ldp_hi: assert property (@(posedge mclk_i) disable iff (rst_i)
    (in_wr && op == orx_pkg::OP_LDP && ldp_pend) |=>
      file_pointer[$past(ldp_sel)][11:8] == $past(ir[3:0]))
    else $error("pointer high nibble not written");

  a_ldp_lo: assert property (@(posedge mclk_i) disable iff (rst_i)
    (in_wr && op == orx_pkg::OP_LDP && !ldp_pend) |=>
      file_pointer[$past(ldp_sel)][7:0] == $past(ir[7:0]))
    else $error("pointer low byte not written");

  a_ldp_sel3: assert property (@(posedge mclk_i) disable iff (rst_i)
    (take && !ldp_pend && is_ldp && instr_i[5:4] == 2'h3) |=>
      !ldp_pend && op == orx_pkg::OP_NONE)
    else $error("selector 3 started a pointer-load");

  a_ldp_w_kept: assert property (@(posedge mclk_i) disable iff (rst_i)
    (in_wr && op == orx_pkg::OP_LDP && !bw_w) |=> $stable(w))
    else $error("pointer-load changed w");

  a_nop_quiet: assert property (@(posedge mclk_i) disable iff (rst_i)
    (in_wr && op == orx_pkg::OP_NONE && !bw_w && !bw_st) |=>
      $stable(w) && $stable(status))
    else $error("no-op word changed w or status");

  a_w_quiet: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ph != orx_pkg::PH_WRITE && !bw_w) |=> $stable(w))
    else $error("w written outside the write phase");

  a_status_quiet: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ph != orx_pkg::PH_WRITE && !bw_st) |=> $stable(status))
    else $error("status written outside the write phase");

  a_flags_other: assert property (@(posedge mclk_i) disable iff (rst_i)
    upd_nz |=> (status & 8'heb) == ($past(status) & 8'heb))
    else $error("flag other than n or z changed");

  a_rdata_w: assert property (@(posedge mclk_i) disable iff (rst_i)
    (bus_i.rd && !bus_mem && bus_off == `ORX_REG_W) |=>
      bus_rdata_o == {8'h00, $past(w)})
    else $error("w read answer wrong");

  a_rdata_ptr: assert property (@(posedge mclk_i) disable iff (rst_i)
    (bus_i.rd && bus_ptr && ptr_idx(bus_off) == 2'h2) |=>
      bus_rdata_o == {4'h0, $past(file_pointer[2])})
    else $error("pointer read answer wrong");

endmodule : orx_exec

// [or_move_fsr_load_exec_bench.sv]
// self-checking bench for the or/move/pointer-load execution block
`timescale 1ns/1ps
`include "orx_defines.svh"
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin fail_count++; $display("ERROR %0t: got %h expected %h", $time, (got), (exp)); end end

module or_move_fsr_load_exec_bench;
  localparam logic [12:0] A_W = {1'b0, `ORX_REG_W};
  localparam logic [12:0] A_ST = {1'b0, `ORX_REG_STATUS};
  localparam logic [12:0] A_BK = {1'b0, `ORX_REG_BANK};
  localparam logic [12:0] A_CT = {1'b0, `ORX_REG_CTRL};
  localparam logic [12:0] A_P0 = {1'b0, `ORX_REG_PTR0};
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [15:0] instr_i = 16'h0000;
  logic instr_valid_i = 1'b0;
  logic instr_ready_o;
  orx_pkg::orx_bus_req_t bus = '0;
  logic [15:0] bus_rdata_o;
  logic [15:0] exp_q[$];
  logic [15:0] e;
  logic rd_q = 1'b0;
  int fail_count = 0;
  int checks = 0;
  logic [7:0] w, k, s;
  logic [11:0] p;

  always #10 mclk_i = ~mclk_i;

  orx_exec orx_exec_inst (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .instr_i(instr_i),
    .instr_valid_i(instr_valid_i),
    .instr_ready_o(instr_ready_o),
    .bus_i(bus),
    .bus_rdata_o(bus_rdata_o)
  );

  // read data stands one cycle only, so the monitor looks mid-cycle after the strobe
  always @(posedge mclk_i) rd_q <= bus.rd;
  always @(negedge mclk_i) begin
    if (rd_q) begin
      e = exp_q.pop_front();
      `CHK(bus_rdata_o, e)
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  task automatic wait_rdy();
    int n;
    n = 0;
    while (instr_ready_o !== 1'b1) begin
      @(negedge mclk_i);
      n++;
      if (n > 20) begin
        fail_count++;
        $display("ERROR %0t: ready never returned", $time);
        results();
      end
    end
  endtask : wait_rdy

  task automatic wr(input logic [12:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge mclk_i);
    bus.wr <= 1'b0;
  endtask : wr

  // reads wait for the core so a pending result has landed
  task automatic rd(input logic [12:0] a, input logic [15:0] x);
    wait_rdy();
    @(posedge mclk_i);
    bus.addr <= a;
    bus.rd <= 1'b1;
    exp_q.push_back(x);
    @(posedge mclk_i);
    bus.rd <= 1'b0;
  endtask : rd

  task automatic ex(input logic [15:0] iw);
    logic [3:0] n;
    wait_rdy();
    @(posedge mclk_i);
    instr_i <= iw;
    instr_valid_i <= 1'b1;
    @(posedge mclk_i);
    instr_valid_i <= 1'b0;
    n = 4'h0;
    do begin
      @(negedge mclk_i);
      n++;
    end while (instr_ready_o !== 1'b1 && n < 4'hf);
    `CHK(n, 4'h4)
    if (n == 4'hf) begin
      results();
    end
  endtask : ex

  function automatic logic [15:0] nz(input logic [7:0] st, input logic [7:0] r);
    logic [7:0] v;
    v = st;
    v[`ORX_ST_N] = r[7];
    v[`ORX_ST_Z] = (r == 8'h00);
    return {8'h00, v};
  endfunction : nz

  initial begin
    void'($urandom(32'h8c80));
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    // every register cleared, unmapped 0x020 reads zero
    for (int i = 0; i < 9; i++) begin
      rd(13'(i * 4), 16'h0000);
    end
    // or-literal, first pass all zero to hit the zero flag
    for (int i = 0; i < 4; i++) begin
      w = (i == 0) ? 8'h00 : 8'($urandom);
      k = (i == 0) ? 8'h00 : 8'($urandom);
      s = 8'($urandom);
      wr(A_W, {8'h00, w});
      wr(A_ST, {8'h00, s});
      ex({8'h09, k});
      rd(A_W, {8'h00, w | k});
      rd(A_ST, nz(s, w | k));
    end
    // or-file through bank 2
    wr(A_BK, 16'h0002);
    wr(13'h1213, 16'h0013);
    wr(A_W, 16'h0091);
    wr(A_ST, 16'h0000);
    ex(16'h1113);
    rd(A_W, 16'h0093);
    rd(A_ST, 16'h0010);
    rd(13'h1213, 16'h0013);
    ex(16'h1313);
    rd(13'h1213, 16'h0093);
    rd(A_W, 16'h0093);
    // move-file, access bank low and high halves, then top of bank 2
    wr(13'h1022, 16'h0000);
    wr(13'h1f80, 16'h0085);
    wr(13'h12ff, 16'h005a);
    wr(A_ST, 16'h0000);
    ex(16'h5022);
    rd(A_W, 16'h0000);
    rd(A_ST, 16'h0004);
    ex(16'h5280);
    rd(A_ST, 16'h0010);
    rd(13'h1f80, 16'h0085);
    rd(A_W, 16'h0000);
    ex(16'h51ff);
    rd(A_W, 16'h005a);
    // pointer loads on selectors 0 to 2 leave flags alone
    wr(A_ST, 16'h00ff);
    for (int i = 0; i < 3; i++) begin
      p = 12'($urandom);
      ex({8'hee, 2'b00, 2'(i), p[11:8]});
      rd(A_P0 + 13'h00c, 16'h0004);
      ex({8'hf0, p[7:0]});
      rd(A_P0 + 13'(4 * i), {4'h0, p});
    end
    // selector 3 does nothing
    ex(16'hee3f);
    ex(16'hf0ff);
    rd(A_P0 + 13'h008, {4'h0, p});
    rd(A_ST, 16'h00ff);
    // indexed literal offset with the extended set on
    ex(16'hee23);
    ex(16'hf0ab);
    rd(A_P0 + 13'h008, 16'h03ab);
    wr(A_CT, 16'h0001);
    wr(13'h13b0, 16'h007e);
    wr(13'h1f60, 16'h0033);
    ex(16'h5005);
    rd(A_W, 16'h007e);
    ex(16'h5060);
    rd(A_W, 16'h0033);
    ex(16'h1205);
    rd(13'h13b0, 16'h007f);
    // mid-run reset clears registers, data memory keeps its contents
    @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(A_W, 16'h0000);
    rd(A_ST, 16'h0000);
    rd(A_BK, 16'h0000);
    rd(A_CT, 16'h0000);
    rd(A_P0 + 13'h008, 16'h0000);
    rd(13'h13b0, 16'h007f);
    repeat (4) @(posedge mclk_i);
    results();
  end
endmodule : or_move_fsr_load_exec_bench
